/* src/io_line_sampler_pkg.sv */
package io_line_sampler_pkg;
  localparam int LINE_COUNT = 13;
  localparam int ANALOG_COUNT = 6;
  localparam int PWM_COUNT = 2;
  localparam int FUNC_W = 4;
  localparam int ADDR_W = 5;
  localparam int ADC_W = 10;
  // pin-function codes
  localparam logic [3:0] FUNC_DISABLED = 4'h0;
  localparam logic [3:0] FUNC_ALT_RESERVED = 4'h1;
  localparam logic [3:0] FUNC_ANALOG_PWM = 4'h2;
  localparam logic [3:0] FUNC_DIGITAL_IN = 4'h3;
  localparam logic [3:0] FUNC_OUT_LOW = 4'h4;
  localparam logic [3:0] FUNC_OUT_HIGH = 4'h5;
  localparam logic [3:0] FUNC_ALT_LOW = 4'h6;
  localparam logic [3:0] FUNC_ALT_HIGH = 4'h9;
  // lines that carry a converter input, pwm-capable lines and alternate-capable lines
  localparam logic [12:0] ANALOG_CAPABLE = 13'h003F;
  localparam logic [12:0] PWM_CAPABLE = 13'h0C00;
  localparam logic [12:0] ALT_CAPABLE = 13'h13E1;
  localparam int PWM_BASE_LINE = 10;
  // packet constants
  localparam logic [7:0] SAMPLE_SET_COUNT = 8'h01;
  localparam logic [7:0] CMD_RESPONSE_TYPE = 8'h88;
  localparam logic [7:0] FRAME_PERIODIC = 8'h00;
  localparam logic [7:0] FRAME_CHANGE = 8'h01;
  localparam logic [7:0] FRAME_WAKE = 8'h02;
  localparam logic [7:0] QUERY_OK = 8'h00;
  localparam logic [7:0] QUERY_ERROR = 8'h01;
  // register indices
  localparam logic [4:0] REG_FUNC_BASE = 5'h00; // 0x00..0x0C: one per line
  localparam logic [4:0] REG_INTERVAL = 5'h10;
  localparam logic [4:0] REG_WATCH = 5'h11;
  localparam logic [4:0] REG_DEST_HI = 5'h12;
  localparam logic [4:0] REG_DEST_LO = 5'h13;
  localparam logic [4:0] REG_FRAMING = 5'h14;
  localparam logic [4:0] REG_WAKE_HOLD = 5'h15;
  localparam logic [4:0] REG_PULL_EN = 5'h16;
  localparam logic [4:0] REG_PULL_POL = 5'h17;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam logic [4:0] REG_QUERY = 5'h19;
  localparam logic [4:0] REG_PWM0 = 5'h1A;
  localparam logic [4:0] REG_PWM1 = 5'h1B;
  localparam logic [12:0] PULL_EN_RESET = 13'h1FFF;
  localparam logic [31:0] DEST_HI_RESET = 32'h00000000;
  localparam logic [31:0] DEST_LO_RESET = 32'h0000FFFF;
  localparam logic [15:0] WAKE_HOLD_RESET = 16'h1388;
  localparam logic [1:0] FRAMING_TRANSPARENT = 2'h0;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [31:0] ZERO32 = 32'h00000000;
endpackage : io_line_sampler_pkg

/* src/io_line_sampler.sv */
`timescale 1ns/10ps
module io_line_sampler #(
  parameter int LINES = io_line_sampler_pkg::LINE_COUNT,
  parameter int ANALOGS = io_line_sampler_pkg::ANALOG_COUNT,
  parameter int MS_CYC = io_line_sampler_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [io_line_sampler_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // pins
  input wire logic [io_line_sampler_pkg::LINE_COUNT-1:0] gpio_line_in,
  output logic [io_line_sampler_pkg::LINE_COUNT-1:0] gpio_line_out,
  output logic [io_line_sampler_pkg::LINE_COUNT-1:0] gpio_line_oe,
  output logic [io_line_sampler_pkg::LINE_COUNT-1:0] pull_enable,
  output logic [io_line_sampler_pkg::LINE_COUNT-1:0] pull_up,
  output logic [io_line_sampler_pkg::PWM_COUNT-1:0] pwm_enable,
  output logic [io_line_sampler_pkg::LINE_COUNT-1:0] alt_enable,
  // converter results, one 16-bit word per channel, channel 0 lowest
  input wire logic [16*io_line_sampler_pkg::ANALOG_COUNT-1:0] analog_result,
  // power state
  input wire logic sleep_enabled,
  input wire logic awake,
  output logic stay_awake,
  // received samples from the radio
  input wire logic rx_sample_valid,
  input wire logic [7:0] rx_sample_byte,
  output logic host_rx_valid,
  output logic [7:0] host_rx_byte,
  // outgoing packet byte stream
  output logic pkt_valid,
  output logic [7:0] pkt_byte,
  output logic pkt_first,
  output logic pkt_last,
  output logic [7:0] pkt_kind,
  output logic [63:0] pkt_dest,
  input wire logic pkt_ready
);
  import io_line_sampler_pkg::*;

  // longest packet: header, digital states, six analog words, one spare
  localparam int MAXB = 4 + 2 + 2 * ANALOG_COUNT + 1;

  // sender states; idle waits for a pending trigger
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } tx_state_e;

  // every register of the block lives in this one struct
  typedef struct packed {
    logic [LINE_COUNT-1:0][FUNC_W-1:0] func;
    logic [15:0] interval;
    logic [LINE_COUNT-1:0] watch;
    logic [31:0] dest_hi;
    logic [31:0] dest_lo;
    logic [1:0] framing;
    logic [15:0] wake_hold;
    logic [LINE_COUNT-1:0] pull_en;
    logic [LINE_COUNT-1:0] pull_pol;
    logic [LINE_COUNT-1:0] sync1;
    logic [LINE_COUNT-1:0] sync2;
    logic [LINE_COUNT-1:0] prev;
    logic awake_prev;
    logic [31:0] cyc_cnt;
    logic [15:0] ms_cnt;
    logic [31:0] hold_cnt;
    logic hold_active;
    logic pend_query;
    logic pend_change;
    logic pend_periodic;
    logic query_error;
    tx_state_e state;
    logic [MAXB-1:0][7:0] buf_b;
    logic [4:0] buf_len;
    logic [4:0] idx;
    logic [7:0] kind;
    logic [31:0] rdata;
    logic [LINE_COUNT-1:0] out_val;
    logic [LINE_COUNT-1:0] out_oe;
    logic [PWM_COUNT-1:0] pwm_en;
    logic [LINE_COUNT-1:0] alt_en;
    logic host_v;
    logic [7:0] host_b;
    logic pv;
    logic [7:0] pb;
    logic pf;
    logic pl;
    logic [7:0] pk;
    logic [63:0] pd;
    logic stay;
  } state_s;

  // q is the registered state, d its next value
  state_s q, d;

  // per-line function decode
  logic [LINE_COUNT-1:0] dig_in, drv, drv_val, pwm_sel, alt_sel;
  logic [ANALOG_COUNT-1:0] ana_in;
  genvar g;
  generate
    for (g = 0; g < LINE_COUNT; g++) begin : g_decode
      assign dig_in[g] = (q.func[g] == FUNC_DIGITAL_IN);
      assign drv[g] = (q.func[g] == FUNC_OUT_LOW) || (q.func[g] == FUNC_OUT_HIGH);
      assign drv_val[g] = (q.func[g] == FUNC_OUT_HIGH);
      assign pwm_sel[g] = PWM_CAPABLE[g] && (q.func[g] == FUNC_ANALOG_PWM);
      // code 1 has no meaning here; 6..9 only on lines offering alternates
      assign alt_sel[g] = ALT_CAPABLE[g] && (q.func[g] >= FUNC_ALT_LOW)
                          && (q.func[g] <= FUNC_ALT_HIGH);
      // only the low lines carry a converter
      if (g < ANALOG_COUNT) begin : g_ana
        assign ana_in[g] = ANALOG_CAPABLE[g] && (q.func[g] == FUNC_ANALOG_PWM);
      end
    end
  endgenerate

  // packet builder: count, masks, optional states, analog words
  logic [MAXB-1:0][7:0] frame;
  logic [4:0] frame_len;
  logic [15:0] dmask, dstates;
  logic [7:0] amask;
  always_comb begin
    dmask = 16'h0000;
    dmask[LINE_COUNT-1:0] = dig_in;
    amask = 8'h00;
    amask[ANALOG_COUNT-1:0] = ana_in;
    dstates = 16'h0000;
    dstates[LINE_COUNT-1:0] = q.sync2 & dig_in;
    frame = '0;
    frame[0] = SAMPLE_SET_COUNT;
    frame[1] = dmask[15:8];
    frame[2] = dmask[7:0];
    frame[3] = amask;
    frame_len = 5'h04;
    // digital states only when some line samples digitally
    if (|dig_in) begin
      frame[frame_len] = dstates[15:8];
      frame[frame_len + 5'h01] = dstates[7:0];
      frame_len = frame_len + 5'h02;
    end
    // analog words high byte first, lowest channel first
    for (int i = 0; i < ANALOG_COUNT; i++) begin
      if (ana_in[i]) begin
        frame[frame_len] = analog_result[16*i+8 +: 8];
        frame[frame_len + 5'h01] = analog_result[16*i +: 8];
        frame_len = frame_len + 5'h02;
      end
    end
  end

  // trigger sources shared by the query, periodic and change paths
  logic any_input;
  logic [LINE_COUNT-1:0] edges;
  logic tick;
  assign any_input = (|dig_in) || (|ana_in);
  assign edges = (q.sync2 ^ q.prev) & q.watch & dig_in;
  // tick marks one millisecond of system clock
  assign tick = (q.cyc_cnt == 32'(MS_CYC - 1));

  always_comb begin
    // defaults hold everything; pulses fall back to zero
    d = q;
    d.host_v = 1'b0;
    // sender first, so a trigger raised in a launch cycle stays pending (set wins)
    // priority: query, then change, then periodic
    unique case (q.state)
      ST_IDLE: begin
        d.pv = 1'b0;
        if (q.pend_query || q.pend_change || q.pend_periodic) begin
          // snapshot the frame so later pin moves cannot tear it
          d.buf_b = frame;
          d.buf_len = frame_len;
          d.idx = 5'h00;
          d.state = ST_SEND;
          if (q.pend_query) begin
            d.pend_query = 1'b0;
            d.kind = CMD_RESPONSE_TYPE;
            // a query reply goes back to the asker, not to the destination
            d.pd = 64'h0;
          end else begin
            if (q.pend_change) begin
              d.pend_change = 1'b0;
              d.kind = FRAME_CHANGE;
            end else begin
              d.pend_periodic = 1'b0;
              d.kind = FRAME_PERIODIC;
            end
            d.pd = {q.dest_hi, q.dest_lo};
          end
        end
      end
      ST_SEND: begin
        // a stalled byte holds until the sink takes it
        if (!q.pv || pkt_ready) begin
          // valid drops one cycle after the last byte is taken
          if (q.pv && q.pl) begin
            d.pv = 1'b0;
            d.state = ST_IDLE;
          end else begin
            d.pv = 1'b1;
            d.pb = q.buf_b[q.idx];
            d.pf = (q.idx == 5'h00);
            d.pl = (q.idx + 5'h01 == q.buf_len);
            d.pk = q.kind;
            d.idx = q.idx + 5'h01;
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase
    // two-stage synchroniser, edge compare only on the second stage
    d.sync1 = gpio_line_in;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // awake_prev clears in reset, so the first awake cycle restarts the hold
    d.awake_prev = awake;
    // millisecond tick and interval counter
    d.cyc_cnt = tick ? ZERO32 : q.cyc_cnt + 32'h1;
    if (q.interval == 16'h0000) begin
      d.ms_cnt = 16'h0000;
    end else if (tick) begin
      if (q.ms_cnt + 16'h1 >= q.interval) begin
        d.ms_cnt = 16'h0000;
        // asleep devices stop once the hold expires
        if (awake && (!sleep_enabled || q.hold_active) && any_input) begin
          d.pend_periodic = 1'b1;
        end
      end else begin
        d.ms_cnt = q.ms_cnt + 16'h1;
      end
    end
    // wake-hold timer in ms
    if (awake && !q.awake_prev) begin
      d.hold_cnt = {16'h0000, q.wake_hold};
      d.hold_active = 1'b1;
      if (q.interval != 16'h0000 && any_input) begin
        d.pend_periodic = 1'b1;
      end
    end else if (tick && q.hold_active) begin
      if (q.hold_cnt == ZERO32) begin
        d.hold_active = 1'b0;
      end else begin
        d.hold_cnt = q.hold_cnt - 32'h1;
      end
    end
    // keep the supply awake only while sleep is allowed and the hold runs
    d.stay = sleep_enabled && q.hold_active;
    // change detect only while awake
    if (awake && (|edges)) begin
      d.pend_change = 1'b1;
    end
    // forward received samples only when api framing is on
    if (rx_sample_valid && q.framing != FRAMING_TRANSPARENT) begin
      d.host_v = 1'b1;
      d.host_b = rx_sample_byte;
    end
    // register access
    d.rdata = ZERO32;
    // writes land at the strobe edge
    if (reg_wr) begin
      if (reg_addr < REG_FUNC_BASE + 5'(LINE_COUNT)) begin
        d.func[reg_addr - REG_FUNC_BASE] = reg_wdata[FUNC_W-1:0];
      end
      // named registers; unmapped writes fall through
      unique case (reg_addr)
        REG_INTERVAL: d.interval = reg_wdata[15:0];
        REG_WATCH: d.watch = reg_wdata[LINE_COUNT-1:0];
        REG_DEST_HI: d.dest_hi = reg_wdata;
        REG_DEST_LO: d.dest_lo = reg_wdata;
        REG_FRAMING: d.framing = reg_wdata[1:0];
        REG_WAKE_HOLD: d.wake_hold = reg_wdata[15:0];
        REG_PULL_EN: d.pull_en = reg_wdata[LINE_COUNT-1:0];
        REG_PULL_POL: d.pull_pol = reg_wdata[LINE_COUNT-1:0];
        REG_QUERY: begin
          // a query with no inputs is refused with an error flag
          if (any_input) begin
            d.pend_query = 1'b1;
            d.query_error = 1'b0;
          end else begin
            d.query_error = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // read data stands for the one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        REG_INTERVAL: d.rdata = {16'h0000, q.interval};
        REG_WATCH: d.rdata = {19'h00000, q.watch};
        REG_DEST_HI: d.rdata = q.dest_hi;
        REG_DEST_LO: d.rdata = q.dest_lo;
        REG_FRAMING: d.rdata = {30'h00000000, q.framing};
        REG_WAKE_HOLD: d.rdata = {16'h0000, q.wake_hold};
        REG_PULL_EN: d.rdata = {19'h00000, q.pull_en};
        REG_PULL_POL: d.rdata = {19'h00000, q.pull_pol};
        REG_STATUS: d.rdata = {16'h0000, 3'h0, q.sync2};
        REG_QUERY: d.rdata = {23'h000000, q.state == ST_SEND, q.query_error ? QUERY_ERROR
                                                                            : QUERY_OK};
        default: begin
          // function registers sit below the named ones; the rest read zero
          if (reg_addr < REG_FUNC_BASE + 5'(LINE_COUNT)) begin
            d.rdata = {28'h0000000, q.func[reg_addr - REG_FUNC_BASE]};
          end
        end
      endcase
    end
    // pin drivers
    d.out_val = drv_val;
    d.out_oe = drv;
    d.pwm_en = pwm_sel[PWM_BASE_LINE +: PWM_COUNT];
    d.alt_en = alt_sel;
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // pulls on, broadcast destination, long wake hold
      q <= '0;
      q.pull_en <= PULL_EN_RESET;
      q.dest_hi <= DEST_HI_RESET;
      q.dest_lo <= DEST_LO_RESET;
      q.wake_hold <= WAKE_HOLD_RESET;
      q.state <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata = q.rdata;
  assign gpio_line_out = q.out_val;
  assign gpio_line_oe = q.out_oe;
  // pull controls go straight to the pad ring
  assign pull_enable = q.pull_en;
  assign pull_up = q.pull_pol;
  assign pwm_enable = q.pwm_en;
  assign alt_enable = q.alt_en;
  assign stay_awake = q.stay;
  // forwarded bytes and the packet stream
  assign host_rx_valid = q.host_v;
  assign host_rx_byte = q.host_b;
  assign pkt_valid = q.pv;
  assign pkt_byte = q.pb;
  assign pkt_first = q.pf;
  assign pkt_last = q.pl;
  assign pkt_kind = q.pk;
  assign pkt_dest = q.pd;
endmodule : io_line_sampler

/* dv/io_line_sampler_sva.sv */
`timescale 1ns/10ps
module io_line_sampler_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [12:0] gpio_line_out,
  input wire logic [12:0] gpio_line_oe,
  input wire logic [12:0] pull_enable,
  input wire logic [1:0] pwm_enable,
  input wire logic [12:0] alt_enable,
  input wire logic sleep_enabled,
  input wire logic stay_awake,
  input wire logic rx_sample_valid,
  input wire logic [7:0] rx_sample_byte,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_byte,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_byte,
  input wire logic pkt_first,
  input wire logic [7:0] pkt_kind,
  input wire logic [63:0] pkt_dest,
  input wire logic pkt_ready
);
  import io_line_sampler_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // pin decode relations
  property p_oe; (gpio_line_out & ~gpio_line_oe) == 13'h0000; endproperty
  a_oe: assert property (p_oe) else $error("high level without enable");
  property p_pwm; pwm_enable[0] |-> !gpio_line_oe[PWM_BASE_LINE]; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm line also driven");
  property p_alt; (alt_enable & (~ALT_CAPABLE | gpio_line_oe)) == 13'h0000; endproperty
  a_alt: assert property (p_alt) else $error("alternate on wrong line");
  property p_pull; !$stable(pull_enable) |-> $past(reg_wr) && $past(reg_addr) == REG_PULL_EN;
  endproperty
  a_pull: assert property (p_pull) else $error("pull enable moved alone");
  // read port and packet stream; a stalled byte must not slip
  property p_rd; !$past(reg_rd) |-> reg_rdata == ZERO32; endproperty
  a_rd: assert property (p_rd) else $error("read data not idle");
  property p_first; $rose(pkt_valid) |-> pkt_first && pkt_byte == SAMPLE_SET_COUNT;
  endproperty
  a_first: assert property (p_first) else $error("packet opens wrongly");
  property p_hold; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_byte); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_qdest; pkt_first && pkt_kind == CMD_RESPONSE_TYPE |-> pkt_dest == 64'h0;
  endproperty
  a_qdest: assert property (p_qdest) else $error("query reply addressed");
  property p_rx; host_rx_valid |-> $past(rx_sample_valid) && host_rx_byte == $past(rx_sample_byte);
  endproperty
  a_rx: assert property (p_rx) else $error("forwarded byte without cause");
  property p_stay; stay_awake |-> $past(sleep_enabled); endproperty
  a_stay: assert property (p_stay) else $error("hold without sleep");
endmodule : io_line_sampler_sva
bind io_line_sampler io_line_sampler_sva i_io_line_sampler_sva (.sys_clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .gpio_line_out, .gpio_line_oe, .pull_enable, .pwm_enable,
  .alt_enable, .sleep_enabled, .stay_awake, .rx_sample_valid, .rx_sample_byte,
  .host_rx_valid, .host_rx_byte, .pkt_valid, .pkt_byte, .pkt_first, .pkt_kind, .pkt_dest,
  .pkt_ready);

/* dv/host_sink.sv */
`timescale 1ns/10ps
module host_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_byte,
  input wire logic pkt_first,
  input wire logic pkt_last,
  input wire logic [7:0] pkt_kind,
  input wire logic [63:0] pkt_dest,
  output logic pkt_ready
);
  logic [7:0] q[$];
  logic [7:0] kind;
  logic [63:0] dest;
  int frames = 0;
  // collects each packet; when slow it stalls at random to test byte holding
  always @(posedge sys_clk) begin
    if (rst) begin
      pkt_ready <= 1'b0;
    end else begin
      if (pkt_valid && pkt_ready) begin
        if (pkt_first) begin
          q.delete();
          kind <= pkt_kind;
          dest <= pkt_dest;
        end
        q.push_back(pkt_byte);
        if (pkt_last) begin
          frames <= frames + 1;
        end
      end
      pkt_ready <= !slow || ($urandom_range(3) == 0);
    end
  end
endmodule : host_sink

/* dv/io_line_sampler_tb.sv */
`timescale 1ns/10ps
module io_line_sampler_tb;
  import io_line_sampler_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [12:0] gpio_line_in = 13'h0;
  logic [95:0] analog_result = 96'h0;
  logic sleep_enabled = 0;
  logic awake = 1;
  logic rx_sample_valid = 0;
  logic [7:0] rx_sample_byte = 8'h00;
  logic slow = 0;
  logic [31:0] reg_rdata;
  logic [12:0] gpio_line_out, gpio_line_oe, pull_enable, pull_up, alt_enable;
  logic [1:0] pwm_enable;
  logic stay_awake, host_rx_valid, pkt_valid, pkt_first, pkt_last, pkt_ready;
  logic [7:0] host_rx_byte, pkt_byte, pkt_kind;
  logic [63:0] pkt_dest;
  logic [3:0] fn[13];
  logic [7:0] exq[$];
  int bad_count = 0;
  int n_checks = 0;
  int nf = 0;
  // short millisecond keeps periodic runs brief
  io_line_sampler #(.MS_CYC(10)) i_io_line_sampler (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .gpio_line_in, .gpio_line_out, .gpio_line_oe, .pull_enable,
    .pull_up, .pwm_enable, .alt_enable, .analog_result, .sleep_enabled, .awake, .stay_awake,
    .rx_sample_valid, .rx_sample_byte, .host_rx_valid, .host_rx_byte, .pkt_valid, .pkt_byte,
    .pkt_first, .pkt_last, .pkt_kind, .pkt_dest, .pkt_ready);
  host_sink i_host_sink (.sys_clk, .rst, .slow, .pkt_valid, .pkt_byte, .pkt_first, .pkt_last,
    .pkt_kind, .pkt_dest, .pkt_ready);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // gap cycle after each strobe so no signal is driven twice in one step
  task automatic wr(logic [4:0] a, logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(logic [4:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic setup();
    for (int i = 0; i < 13; i++) wr(5'(i), {28'h0, fn[i]});
    repeat (2) @(posedge sys_clk);
  endtask : setup
  task automatic rx(logic [7:0] b, logic e);
    rx_sample_byte <= b;
    rx_sample_valid <= 1'b1;
    @(posedge sys_clk);
    rx_sample_valid <= 1'b0;
    #1 chk("host_rx_valid", host_rx_valid, e);
    if (e) chk("host_rx_byte", host_rx_byte, b);
    @(posedge sys_clk);
  endtask : rx
  function automatic logic [12:0] dmask();
    logic [12:0] m;
    foreach (fn[i]) m[i] = (fn[i] == FUNC_DIGITAL_IN);
    return m;
  endfunction : dmask
  // expected bytes from line setup, pins and converter words
  function automatic void model();
    logic [12:0] m;
    logic [7:0] am;
    m = dmask();
    am = 8'h00;
    for (int i = 0; i < ANALOG_COUNT; i++) am[i] = (fn[i] == FUNC_ANALOG_PWM);
    exq = {};
    exq.push_back(SAMPLE_SET_COUNT);
    exq.push_back({3'b000, m[12:8]});
    exq.push_back(m[7:0]);
    exq.push_back(am);
    if (m != 13'h0) begin
      exq.push_back({3'b000, gpio_line_in[12:8] & m[12:8]});
      exq.push_back(gpio_line_in[7:0] & m[7:0]);
    end
    for (int i = 0; i < ANALOG_COUNT; i++) begin
      if (am[i]) begin
        exq.push_back(analog_result[16*i+8 +: 8]);
        exq.push_back(analog_result[16*i +: 8]);
      end
    end
  endfunction : model
  // bounded wait for the next frame, then byte-by-byte compare
  task automatic frame(logic [7:0] kd, int lim);
    nf++;
    for (int k = 0; k < lim && i_host_sink.frames < nf; k++) @(posedge sys_clk);
    chk("frame_done", i_host_sink.frames >= nf, 1'b1);
    chk("kind", i_host_sink.kind, kd);
    chk("length", i_host_sink.q.size(), exq.size());
    foreach (exq[i]) chk("byte", i_host_sink.q[i], exq[i]);
  endtask : frame
  task automatic results();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    logic [31:0] v;
    v = $urandom(32'hD2584726);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("pull_enable", pull_enable, PULL_EN_RESET);
    rd(REG_WAKE_HOLD, v);
    chk("wake_hold", v, WAKE_HOLD_RESET);
    rd(5'h1F, v);
    chk("unmapped", v, ZERO32);
    wr(REG_QUERY, 32'h1);
    rd(REG_QUERY, v);
    chk("query_error", v[7:0], QUERY_ERROR);
    chk("frames", i_host_sink.frames, 0);
    for (int c = 0; c < 10; c++) begin
      foreach (fn[i]) fn[i] = 4'(c);
      setup();
      chk("oe", gpio_line_oe, (c == 4 || c == 5) ? 13'h1FFF : 13'h0);
      chk("out", gpio_line_out, (c == 5) ? 13'h1FFF : 13'h0);
      chk("pwm", pwm_enable, (c == 2) ? 2'b11 : 2'b00);
      chk("alt", alt_enable, (c >= 6) ? ALT_CAPABLE : 13'h0);
    end
    for (int r = 0; r < 3; r++) begin
      foreach (fn[i]) fn[i] = (r == 0) ? ((i == 5) ? 4'h2 : 4'h0) : 4'($urandom_range(5));
      if (r > 0) fn[12] = FUNC_DIGITAL_IN;
      gpio_line_in <= 13'($urandom()) & dmask();
      analog_result <= {$urandom(), $urandom(), $urandom()} & {6{16'h03FF}};
      slow <= (r == 1);
      v = $urandom();
      wr(REG_PULL_EN, v);
      chk("pull_en", pull_enable, v[12:0]);
      wr(REG_PULL_POL, v >> 13);
      chk("pull_up", pull_up, v[25:13]);
      setup();
      rd(5'h0C, v);
      chk("func_rd", v, {28'h0, fn[12]});
      model();
      wr(REG_QUERY, 32'h1);
      frame(CMD_RESPONSE_TYPE, 400);
    end
    wr(REG_DEST_HI, 32'h0A0B0C0D);
    wr(REG_DEST_LO, 32'h00001F2E);
    wr(REG_INTERVAL, 32'h2);
    frame(FRAME_PERIODIC, 100);
    chk("dest", i_host_sink.dest, 64'h0A0B0C0D00001F2E);
    wr(REG_INTERVAL, 32'h0);
    repeat (60) @(posedge sys_clk);
    nf = i_host_sink.frames;
    repeat (200) @(posedge sys_clk);
    chk("idle", i_host_sink.frames, nf);
    wr(REG_WATCH, 32'h1000);
    gpio_line_in <= gpio_line_in ^ 13'h1000;
    @(posedge sys_clk);
    model();
    frame(FRAME_CHANGE, 60);
    repeat (100) @(posedge sys_clk);
    chk("one_edge", i_host_sink.frames, nf);
    awake <= 1'b0;
    gpio_line_in <= gpio_line_in ^ 13'h1000;
    repeat (100) @(posedge sys_clk);
    chk("asleep", i_host_sink.frames, nf);
    wr(REG_WATCH, 32'h0);
    wr(REG_INTERVAL, 32'd200);
    model();
    awake <= 1'b1;
    sleep_enabled <= 1'b1;
    frame(FRAME_PERIODIC, 100);
    chk("stay_awake", stay_awake, 1'b1);
    // short hold: periodic samples stop once it runs out
    wr(REG_WAKE_HOLD, 32'h3);
    wr(REG_INTERVAL, 32'h2);
    awake <= 1'b0;
    @(posedge sys_clk);
    awake <= 1'b1;
    repeat (80) @(posedge sys_clk);
    chk("hold_end", stay_awake, 1'b0);
    nf = i_host_sink.frames;
    repeat (100) @(posedge sys_clk);
    chk("hold_over", i_host_sink.frames, nf);
    rx(8'hA5, 1'b0);
    wr(REG_FRAMING, 32'h1);
    rx(8'h5A, 1'b1);
    results();
  end
endmodule : io_line_sampler_tb
